/* File: dat_pkg.sv */
// constants and types of the acquisition timing block
package dat_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL                    = 8'h00;
  localparam logic [7:0] OFS_CMD                     = 8'h04;
  localparam logic [7:0] OFS_SAMPLE_INTERVAL_DIVIDER = 8'h08;
  localparam logic [7:0] OFS_SAMPLE_TOTAL_COUNT      = 8'h0C;
  localparam logic [7:0] OFS_TRIGGER_DELAY_COUNT     = 8'h10;
  localparam logic [7:0] OFS_TRACE_REPEAT_COUNT      = 8'h14;
  localparam logic [7:0] OFS_PRETRIG_AMOUNT          = 8'h18;
  localparam logic [7:0] OFS_STATUS                  = 8'h1C;
  localparam logic [7:0] OFS_TRACES_DONE             = 8'h20;

  // ----------------------------------------------------------------
  // command bits, reset values, limits
  // ----------------------------------------------------------------
  localparam int unsigned CMD_START  = 0;
  localparam int unsigned CMD_SWTRIG = 1;
  localparam int unsigned CMD_STOP   = 2;

  localparam logic [15:0] RST_INTERVAL = 16'h0001;
  localparam logic [27:0] RST_TOTAL    = 28'h0000001;
  localparam logic [15:0] RST_DELAY    = 16'h0001;
  localparam logic [30:0] RST_REPEAT   = 31'h00000001;
  localparam logic [27:0] RST_PRETRIG  = 28'h0000000;

  localparam logic [27:0] TOTAL_MAX      = 28'hFFFFFFC;
  localparam logic [27:0] TOTAL_MAX_AVG2 = 28'h7FFFFFC;
  localparam logic [30:0] REPEAT_MAX_AVG = 31'h0000FFFF;

  localparam logic [2:0]  TRIG_OUT_CYC = 3'h4;
  localparam int unsigned AVG_AW       = 10;
  localparam int unsigned AVG_DEPTH    = 1024;
  localparam int unsigned CTRL_W       = 17;

  // ----------------------------------------------------------------
  // positions in the synchroniser vector
  // ----------------------------------------------------------------
  localparam int unsigned SY_TB    = 0;
  localparam int unsigned SY_EXT   = 1;
  localparam int unsigned SY_SHTRG = 2;
  localparam int unsigned SY_OSC   = 3;
  localparam int unsigned SY_RDY   = 4;
  localparam int unsigned SY_SW    = 8;
  localparam int unsigned SY_ADC   = 12;
  localparam int unsigned SY_SHTB  = 44;
  localparam int unsigned SYNC_W   = 45;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_POST  = 2'h0,
    MODE_DELAY = 2'h1,
    MODE_PRE   = 2'h2,
    MODE_MID   = 2'h3
  } dat_mode_t;

  typedef enum logic [1:0] {
    CLK_INT     = 2'h0,
    CLK_EXT_REF = 2'h1,
    CLK_EXT_SMP = 2'h2
  } dat_clk_t;

  typedef enum logic [1:0] {
    REF_OSC    = 2'h0,
    REF_CLKIN  = 2'h1,
    REF_SHARED = 2'h2
  } dat_ref_t;

  typedef enum logic [1:0] {
    TSRC_SW  = 2'h0,
    TSRC_EXT = 2'h1,
    TSRC_BUS = 2'h2
  } dat_tsrc_t;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_PRE   = 6'h02,
    ST_ARMED = 6'h04,
    ST_DELAY = 6'h08,
    ST_ACQ   = 6'h10,
    ST_GUARD = 6'h20
  } dat_state_t;

  typedef struct packed {
    logic [3:0] rdy_mask;
    logic [1:0] rdy_sel;
    logic       ext_fall;
    dat_tsrc_t  trig_src;
    logic       slave;
    logic       master;
    dat_clk_t   clk_sel;
    logic       two_ch;
    logic       avg;
    dat_mode_t  mode;
  } dat_ctrl_t;

  typedef struct packed {
    logic [15:0] ch1;
    logic [15:0] ch0;
  } dat_smp_t;

endpackage : dat_pkg

/* File: dat_sync3.sv */
// three-stage input synchroniser with edge pulses
`timescale 1ns/10ps
module dat_sync3
  import dat_pkg::*;
#(
  parameter int unsigned W = 1
) (
  input  wire logic         i_core_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q,
  output logic      [W-1:0] o_rise,
  output logic      [W-1:0] o_fall
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
    logic [W-1:0] rise;
    logic [W-1:0] fall;
  } dat_sync_st_t;

  dat_sync_st_t s_r;
  dat_sync_st_t s_nxt;
  logic [W-1:0] agree;

  always_comb begin
    s_nxt    = s_r;
    s_nxt.s1 = i_d;
    s_nxt.s2 = s_r.s1;
    s_nxt.s3 = s_r.s2;
    // a change counts only once stages two and three agree
    agree      = ~(s_r.s2 ^ s_r.s3);
    s_nxt.q    = (agree & s_r.s3) | (~agree & s_r.q);
    s_nxt.rise = s_nxt.q & ~s_r.q;
    s_nxt.fall = ~s_nxt.q & s_r.q;
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_q    = s_r.q;
  assign o_rise = s_r.rise;
  assign o_fall = s_r.fall;

endmodule : dat_sync3

/* File: dat_acq_timing.sv */
// acquisition timing engine
// Operation
// RULE1 - averaging works only in post-trigger or delayed-trigger mode
// RULE2 - without averaging each accepted trigger yields one N-sample trace
// RULE3 - averaging outputs one N-sample trace, each the mean over R traces; code stores only AVG_DEPTH positions, longer totals wrap
// RULE4 - internal reference: onboard 10MHz oscillator feeds the 200MHz synth
// RULE5 - external reference: synth input taken from clock-in, must be 10MHz
// RULE6 - external sampling clock drives converter directly, 40 to 200MHz
// RULE7 - acquisition starts only on an accepted software, external or bus trigger
// RULE8 - one sample per divider-count timebase rising edges, written to FIFO
// RULE9 - FIFO data goes to DMA whenever FIFO is not empty
// RULE10 - acquisition ends when stored samples reach programmed total
// RULE11 - 16-bit sample interval divider, rate equals timebase over divider
// RULE12 - 28-bit sample total, limit halves for two-channel averaging
// RULE13 - 16-bit trigger delay counts timebase periods before first sample
// RULE14 - 31-bit trace repeat count, limited to 65535 when averaging
// RULE15 - each sync line carries one signal only
// RULE16 - card number from four sliders, ON is 0, slider 1 is MSB
// RULE17 - master drives onboard 10MHz on shared timebase, slave uses it
// RULE18 - master drives shared trigger, slave takes its rising edges
// RULE19 - master must be pre or mid mode when any slave is
// RULE20 - slave in pre or mid mode signals readiness on its own line
// RULE21 - master in pre or mid mode receives slave readiness lines
// RULE22 - triggers too close after previous one are ignored
// RULE23 - master accepts pre or mid trigger only after all fills done
// RULE24 - divider value 1 samples on every timebase rising edge
`timescale 1ns/10ps
module dat_acq_timing
  import dat_pkg::*;
(
  input  wire logic       i_core_clk,
  input  wire logic       i_rst,
  input  wire logic [7:0] i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [31:0] o_rdata,
  input  wire logic       i_timebase,
  input  wire logic       i_ext_trig,
  input  wire logic       i_ref_osc,
  input  wire logic       i_shared_timebase_line_in,
  output logic            o_shared_timebase_line_out,
  output logic            o_shared_timebase_line_oe,
  input  wire logic       i_shared_trigger_line_in,
  output logic            o_shared_trigger_line_out,
  output logic            o_shared_trigger_line_oe,
  input  wire logic [3:0] i_pretrigger_fill_done_in,
  output logic      [3:0] o_pretrigger_fill_done_out,
  output logic      [3:0] o_pretrigger_fill_done_oe,
  input  wire logic [3:0] i_card_switch,
  input  wire logic [15:0] i_adc_ch0,
  input  wire logic [15:0] i_adc_ch1,
  output logic            o_fifo_wr,
  output dat_smp_t        o_fifo_data,
  input  wire logic       i_fifo_empty,
  output logic            o_dma_req,
  output dat_ref_t        o_synth_ref_sel,
  output logic            o_adc_clk_direct
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    dat_ctrl_t   ctrl;
    logic [15:0] sample_interval_divider;
    logic [27:0] sample_total_count;
    logic [15:0] trigger_delay_count;
    logic [30:0] trace_repeat_count;
    logic [27:0] pretrig_amount;
    dat_state_t  st;
    logic [15:0] div;
    logic [15:0] dly;
    logic [27:0] smp;
    logic [30:0] trc;
    logic [27:0] pre;
    logic        fill;
    logic        done;
    logic        swtrig;
    logic [2:0]  tout;
    logic [31:0] rdata;
    logic        fwr;
    dat_smp_t    fdata;
    logic [3:0]  card;
    logic        tb_out;
  } dat_st_t;

  dat_st_t s_r;
  dat_st_t s_nxt;

  logic [SYNC_W-1:0] sy_q;
  logic [SYNC_W-1:0] sy_rise;
  logic [SYNC_W-1:0] sy_fall;

  // ----------------------------------------------------------------
  // input synchronisation
  // ----------------------------------------------------------------
  dat_sync3 #(
    .W (SYNC_W)
  ) u_sync (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_d        ({i_shared_timebase_line_in, i_adc_ch1, i_adc_ch0, i_card_switch,
                  i_pretrigger_fill_done_in, i_ref_osc, i_shared_trigger_line_in,
                  i_ext_trig, i_timebase}),
    .o_q        (sy_q),
    .o_rise     (sy_rise),
    .o_fall     (sy_fall)
  );

  // ----------------------------------------------------------------
  // effective settings
  // ----------------------------------------------------------------
  logic        tick;
  logic        avg_on;
  logic        premid;
  logic [15:0] eff_div;
  logic [15:0] eff_delay;
  logic [27:0] tot_lim;
  logic [27:0] eff_total;
  logic [30:0] eff_rep;
  logic        last_trc;
  logic        sampling;
  logic        ps;
  logic        trig;
  logic        bus_ok;
  logic [1:0][15:0] adc_s;
  logic [1:0][15:0] avg_q;
  logic [AVG_AW-1:0] pos;
  logic        mem_we;

  assign tick   = sy_rise[SY_TB];
  assign adc_s  = sy_q[SY_ADC +: 32];
  assign premid = (s_r.ctrl.mode == MODE_PRE) || (s_r.ctrl.mode == MODE_MID);
  // RULE1 averaging gate
  assign avg_on = s_r.ctrl.avg && !premid;
  // RULE11 RULE24 zero behaves as one
  assign eff_div   = (s_r.sample_interval_divider == 16'h0000) ? 16'h0001
                     : s_r.sample_interval_divider;
  assign eff_delay = (s_r.trigger_delay_count == 16'h0000) ? 16'h0001
                     : s_r.trigger_delay_count;
  // RULE12 total limit
  assign tot_lim   = (avg_on && s_r.ctrl.two_ch) ? TOTAL_MAX_AVG2 : TOTAL_MAX;
  assign eff_total = (s_r.sample_total_count == 28'h0000000) ? 28'h0000001
                     : (s_r.sample_total_count > tot_lim) ? tot_lim
                     : s_r.sample_total_count;
  // RULE14 repeat limit
  assign eff_rep   = (s_r.trace_repeat_count == 31'h00000000) ? 31'h00000001
                     : (avg_on && s_r.trace_repeat_count > REPEAT_MAX_AVG) ? REPEAT_MAX_AVG
                     : s_r.trace_repeat_count;
  assign last_trc  = premid || ((s_r.trc + 31'h00000001) >= eff_rep);

  // RULE8 sample period strobe
  assign sampling = (s_r.st == ST_PRE) || (s_r.st == ST_ACQ) || (s_r.st == ST_GUARD);
  assign ps       = tick && sampling && (s_r.div >= (eff_div - 16'h0001));

  // RULE7 RULE18 trigger source
  always_comb begin
    trig = 1'b0;
    if (s_r.ctrl.slave) begin
      trig = sy_rise[SY_SHTRG];
    end else begin
      case (s_r.ctrl.trig_src)
        TSRC_SW:  trig = s_r.swtrig;
        TSRC_EXT: trig = s_r.ctrl.ext_fall ? sy_fall[SY_EXT] : sy_rise[SY_EXT];
        TSRC_BUS: trig = sy_rise[SY_SHTRG];
      endcase
    end
  end

  // RULE21 RULE23 masked slave readiness
  assign bus_ok = !s_r.ctrl.master
                  || (&(sy_q[SY_RDY +: 4] | ~s_r.ctrl.rdy_mask));

  // ----------------------------------------------------------------
  // averaging store, one accumulator array per channel
  // ----------------------------------------------------------------
  // depth limits averaged traces to AVG_DEPTH samples; longer totals wrap
  assign pos    = s_r.smp[AVG_AW-1:0];
  assign mem_we = ps && (s_r.st == ST_ACQ) && avg_on && !last_trc;

  for (genvar c = 0; c < 2; c++) begin : g_avg
    logic signed [31:0] mem [AVG_DEPTH];
    logic signed [31:0] acc;
    logic signed [31:0] sum;
    logic signed [31:0] quo;

    // RULE3 running sum per position
    assign acc = (s_r.trc == 31'h00000000) ? 32'sh00000000 : mem[pos];
    assign sum = acc + {{16{adc_s[c][15]}}, adc_s[c]};
    assign quo = sum / $signed({16'h0000, eff_rep[15:0]});
    assign avg_q[c] = quo[15:0];

    always_ff @(posedge i_core_clk) begin
      if (mem_we) begin
        mem[pos] <= sum;
      end
    end
  end

  // ----------------------------------------------------------------
  // registers and sequencer
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt        = s_r;
    s_nxt.rdata  = 32'h00000000;
    s_nxt.fwr    = 1'b0;
    s_nxt.swtrig = 1'b0;
    if (s_r.tout != 3'h0) begin
      s_nxt.tout = s_r.tout - 3'h1;
    end
    // RULE16 slider 1 on bit 3, ON reads low
    s_nxt.card   = sy_q[SY_SW +: 4];
    // RULE17 reference copy
    s_nxt.tb_out = sy_q[SY_OSC];

    if (i_wr) begin
      if (i_addr == OFS_CTRL) begin
        s_nxt.ctrl = dat_ctrl_t'(i_wdata[CTRL_W-1:0]);
      end else if (i_addr == OFS_SAMPLE_INTERVAL_DIVIDER) begin
        s_nxt.sample_interval_divider = i_wdata[15:0];
      end else if (i_addr == OFS_SAMPLE_TOTAL_COUNT) begin
        s_nxt.sample_total_count = i_wdata[27:0];
      end else if (i_addr == OFS_TRIGGER_DELAY_COUNT) begin
        s_nxt.trigger_delay_count = i_wdata[15:0];
      end else if (i_addr == OFS_TRACE_REPEAT_COUNT) begin
        s_nxt.trace_repeat_count = i_wdata[30:0];
      end else if (i_addr == OFS_PRETRIG_AMOUNT) begin
        s_nxt.pretrig_amount = i_wdata[27:0];
      end else if (i_addr == OFS_CMD) begin
        s_nxt.swtrig = i_wdata[CMD_SWTRIG];
      end
    end

    if (i_rd) begin
      if (i_addr == OFS_CTRL) begin
        s_nxt.rdata = {15'h0000, s_r.ctrl};
      end else if (i_addr == OFS_SAMPLE_INTERVAL_DIVIDER) begin
        s_nxt.rdata = {16'h0000, s_r.sample_interval_divider};
      end else if (i_addr == OFS_SAMPLE_TOTAL_COUNT) begin
        s_nxt.rdata = {4'h0, s_r.sample_total_count};
      end else if (i_addr == OFS_TRIGGER_DELAY_COUNT) begin
        s_nxt.rdata = {16'h0000, s_r.trigger_delay_count};
      end else if (i_addr == OFS_TRACE_REPEAT_COUNT) begin
        s_nxt.rdata = {1'h0, s_r.trace_repeat_count};
      end else if (i_addr == OFS_PRETRIG_AMOUNT) begin
        s_nxt.rdata = {4'h0, s_r.pretrig_amount};
      end else if (i_addr == OFS_STATUS) begin
        s_nxt.rdata = {19'h00000, sy_q[SY_SHTB], s_r.fill, s_r.done, s_r.card, s_r.st};
      end else if (i_addr == OFS_TRACES_DONE) begin
        s_nxt.rdata = {1'h0, s_r.trc};
      end
    end

    // RULE8 RULE11 sample divider
    if (tick && sampling) begin
      s_nxt.div = ps ? 16'h0000 : (s_r.div + 16'h0001);
    end

    case (s_r.st)
      ST_IDLE: begin
        if (i_wr && (i_addr == OFS_CMD) && i_wdata[CMD_START]) begin
          s_nxt.smp  = 28'h0000000;
          s_nxt.trc  = 31'h00000000;
          s_nxt.pre  = 28'h0000000;
          s_nxt.fill = 1'b0;
          s_nxt.done = 1'b0;
          s_nxt.div  = eff_div - 16'h0001;
          s_nxt.st   = premid ? ST_PRE : ST_ARMED;
        end
      end
      ST_PRE: begin
        if (ps) begin
          s_nxt.fwr   = 1'b1;
          s_nxt.fdata = adc_s;
          if (s_r.pre < s_r.pretrig_amount) begin
            s_nxt.pre = s_r.pre + 28'h0000001;
          end
        end
        s_nxt.fill = s_nxt.pre >= s_r.pretrig_amount;
        // RULE23 fill gate before trigger
        if (trig && s_r.fill && bus_ok) begin
          s_nxt.tout = TRIG_OUT_CYC;
          if (s_r.ctrl.mode == MODE_PRE) begin
            s_nxt.done = 1'b1;
            s_nxt.st   = ST_IDLE;
          end else begin
            s_nxt.smp = 28'h0000000;
            s_nxt.div = eff_div - 16'h0001;
            s_nxt.st  = ST_ACQ;
          end
        end
      end
      ST_ARMED: begin
        // RULE7 trigger starts trace
        if (trig) begin
          s_nxt.tout = TRIG_OUT_CYC;
          s_nxt.smp  = 28'h0000000;
          s_nxt.div  = eff_div - 16'h0001;
          if (s_r.ctrl.mode == MODE_DELAY) begin
            s_nxt.dly = eff_delay;
            s_nxt.st  = ST_DELAY;
          end else begin
            s_nxt.st  = ST_ACQ;
          end
        end
      end
      ST_DELAY: begin
        // RULE13 delay in ticks
        if (tick) begin
          if (s_r.dly <= 16'h0001) begin
            s_nxt.st = ST_ACQ;
          end else begin
            s_nxt.dly = s_r.dly - 16'h0001;
          end
        end
      end
      ST_ACQ: begin
        if (ps) begin
          // RULE2 RULE3 plain trace or averaged final pass
          s_nxt.fwr   = !avg_on || last_trc;
          s_nxt.fdata = avg_on ? avg_q : adc_s;
          s_nxt.smp   = s_r.smp + 28'h0000001;
          // RULE10 end of trace at programmed total
          if ((s_r.smp + 28'h0000001) >= eff_total) begin
            s_nxt.smp = 28'h0000000;
            if (last_trc) begin
              s_nxt.done = 1'b1;
              s_nxt.st   = ST_IDLE;
            end else begin
              s_nxt.trc = s_r.trc + 31'h00000001;
              s_nxt.st  = ST_GUARD;
            end
          end
        end
      end
      ST_GUARD: begin
        // RULE22 re-arm guard
        if (ps) begin
          s_nxt.st = ST_ARMED;
        end
      end
      default: begin
        s_nxt.st = ST_IDLE;
      end
    endcase

    if (i_wr && (i_addr == OFS_CMD) && i_wdata[CMD_STOP]) begin
      s_nxt.st = ST_IDLE;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      s_r                         <= '0;
      s_r.sample_interval_divider <= RST_INTERVAL;
      s_r.sample_total_count      <= RST_TOTAL;
      s_r.trigger_delay_count     <= RST_DELAY;
      s_r.trace_repeat_count      <= RST_REPEAT;
      s_r.pretrig_amount          <= RST_PRETRIG;
      s_r.st                      <= ST_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_rdata     = s_r.rdata;
  assign o_fifo_wr   = s_r.fwr;
  assign o_fifo_data = s_r.fdata;
  // RULE9 drain at once
  assign o_dma_req   = !i_fifo_empty;

  // RULE4 RULE5 RULE6 RULE17 clock source steering
  always_comb begin
    if (s_r.ctrl.slave) begin
      o_synth_ref_sel = REF_SHARED;
    end else if (s_r.ctrl.clk_sel == CLK_EXT_REF) begin
      o_synth_ref_sel = REF_CLKIN;
    end else begin
      o_synth_ref_sel = REF_OSC;
    end
  end
  assign o_adc_clk_direct = !s_r.ctrl.slave && (s_r.ctrl.clk_sel == CLK_EXT_SMP);

  // RULE17 master drives the reference out
  assign o_shared_timebase_line_out = s_r.tb_out;
  assign o_shared_timebase_line_oe  = s_r.ctrl.master && !s_r.ctrl.slave;

  // RULE18 stretched trigger so slaves on other clocks catch it
  assign o_shared_trigger_line_out = s_r.tout != 3'h0;
  assign o_shared_trigger_line_oe  = s_r.ctrl.master && !s_r.ctrl.slave;

  // RULE15 RULE20 own readiness line
  assign o_pretrigger_fill_done_out = {4{s_r.fill}};
  assign o_pretrigger_fill_done_oe  = (s_r.ctrl.slave && premid)
                                      ? (4'h1 << s_r.ctrl.rdy_sel) : 4'h0;

endmodule : dat_acq_timing

/* File: dat_acq_timing_checker.sv */
// assertions of the acquisition timing engine
`timescale 1ns/10ps
module dat_acq_timing_checker
  import dat_pkg::*;
(
  input wire logic        i_core_clk,
  input wire logic        i_rst,
  input wire logic        i_rd,
  input wire logic        i_fifo_empty,
  input wire logic [31:0] o_rdata,
  input wire logic        o_dma_req,
  input wire logic        o_fifo_wr,
  input wire logic        o_shared_trigger_line_out,
  input wire logic        o_shared_trigger_line_oe,
  input wire logic        o_shared_timebase_line_oe,
  input wire logic [3:0]  o_pretrigger_fill_done_oe,
  input wire logic        o_adc_clk_direct,
  input wire dat_ref_t    o_synth_ref_sel
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  AST_DMA_FOLLOWS_FIFO: assert property (o_dma_req == !i_fifo_empty)
    else $error("dma request");
  // ticks eight cycles apart
  AST_SAMPLE_SPACING: assert property (o_fifo_wr |=> !o_fifo_wr [*4])
    else $error("fifo spacing");
  AST_TRIG_OUT_WIDTH: assert property ($rose(o_shared_trigger_line_out) |->
    o_shared_trigger_line_out [*4] ##1 !o_shared_trigger_line_out)
    else $error("trigger width");
  AST_MASTER_DRIVES_BOTH: assert property (
    o_shared_trigger_line_oe == o_shared_timebase_line_oe)
    else $error("enables differ");
  AST_READY_ONE_LINE: assert property ($onehot0(o_pretrigger_fill_done_oe))
    else $error("two ready lines");
  AST_SLAVE_NOT_MASTER: assert property (|o_pretrigger_fill_done_oe |->
    !o_shared_trigger_line_oe && !o_shared_timebase_line_oe)
    else $error("slave drives master");
  AST_DIRECT_NOT_SHARED: assert property (
    o_adc_clk_direct |-> o_synth_ref_sel != REF_SHARED)
    else $error("direct on slave");
  AST_RDATA_ONE_CYCLE: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("stale rdata");
  cover property (o_fifo_wr);
  cover property ($rose(o_shared_trigger_line_out));
  cover property (|o_pretrigger_fill_done_oe);
endmodule : dat_acq_timing_checker

bind dat_acq_timing dat_acq_timing_checker u_chk (.*);

/* File: dat_sync_peer.sv */
// peer module on the sync connector
`timescale 1ns/10ps
module dat_sync_peer (
  input  wire logic       i_core_clk,
  input  wire logic       i_rst,
  input  wire logic       i_fire,
  input  wire logic [3:0] i_rdy,
  output logic            o_trig,
  output logic            o_tb,
  output logic      [3:0] o_rdy
);
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_trig <= 1'h0;
      o_tb   <= 1'h0;
      o_rdy  <= 4'h0;
    end else begin
      o_trig <= i_fire;
      o_tb   <= ~o_tb;
      o_rdy  <= i_rdy;
    end
  end
endmodule : dat_sync_peer

/* File: dat_acq_timing_tb_top.sv */
// bench of the acquisition timing engine
`timescale 1ns/10ps
module dat_acq_timing_tb_top
  import dat_pkg::*;
;
  typedef struct packed {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] e;} dat_row_t;
  logic        clk, rst, wr_s, rd_s, tb, etrig, osc, pfire, empty, direct, tro, troe;
  logic        tbo, tboe, ptrig, ptb, tro_d, fwr, dma, trig_in, tb_in;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, got;
  logic [3:0]  sw, prdy, prdy_o, roe, rout, rdy_in;
  logic [15:0] a0, a1;
  dat_smp_t    fdat, last;
  dat_ref_t    rsel;
  int          bad_count, checks, nwr, ntro, cyc, tfirst, tlast, tprev, ttrg, p0;
  dat_row_t    rows [12] = '{'{8'h00, 1'h0, 32'h0, 32'h0}, '{8'h08, 1'h0, 32'h0, 32'h1},
    '{8'h0C, 1'h0, 32'h0, 32'h1}, '{8'h10, 1'h0, 32'h0, 32'h1}, '{8'h14, 1'h0, 32'h0, 32'h1},
    '{8'h18, 1'h0, 32'h0, 32'h0}, '{8'h20, 1'h0, 32'h0, 32'h0},
    '{8'h08, 1'h1, 32'hFFFFFFFF, 32'hFFFF}, '{8'h10, 1'h1, 32'hFFFFFFFF, 32'hFFFF},
    '{8'h14, 1'h1, 32'hFFFFFFFF, 32'h7FFFFFFF}, '{8'h04, 1'h1, 32'h0, 32'h0},
    '{8'h24, 1'h1, 32'hFFFFFFFF, 32'h0}};
  // shared lines: enabled driver wins
  assign trig_in = troe ? tro : ptrig;
  assign tb_in   = tboe ? tbo : ptb;
  assign rdy_in  = (roe & rout) | (~roe & prdy_o);
  dat_acq_timing uut (.i_core_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata), .i_timebase(tb), .i_ext_trig(etrig),
    .i_ref_osc(osc), .i_shared_timebase_line_in(tb_in), .o_shared_timebase_line_out(tbo),
    .o_shared_timebase_line_oe(tboe), .i_shared_trigger_line_in(trig_in),
    .o_shared_trigger_line_out(tro), .o_shared_trigger_line_oe(troe),
    .i_pretrigger_fill_done_in(rdy_in), .o_pretrigger_fill_done_out(rout),
    .o_pretrigger_fill_done_oe(roe), .i_card_switch(sw), .i_adc_ch0(a0), .i_adc_ch1(a1),
    .o_fifo_wr(fwr), .o_fifo_data(fdat), .i_fifo_empty(empty), .o_dma_req(dma),
    .o_synth_ref_sel(rsel), .o_adc_clk_direct(direct));
  dat_sync_peer peer (.i_core_clk(clk), .i_rst(rst), .i_fire(pfire), .i_rdy(prdy),
    .o_trig(ptrig), .o_tb(ptb), .o_rdy(prdy_o));
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  // timebase off the clock edges
  initial begin
    tb = 1'h0;
    #13;
    forever #200 tb = ~tb;
  end
  initial begin
    osc = 1'h0;
    forever #50 osc = ~osc;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    empty <= cyc[3];
    tro_d <= tro;
    if (tro === 1'h1 && tro_d !== 1'h1) ntro <= ntro + 1;
    if (fwr === 1'h1) begin
      if (nwr == 0) tfirst <= cyc;
      nwr <= nwr + 1;
      tprev <= tlast;
      tlast <= cyc;
      last <= fdat;
    end
  end
  // ----------------------------------------------------------------
  // bus, compare and stimulus tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'h1;
    @(posedge clk);
    wr_s <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'h1;
    @(posedge clk);
    rd_s <= 1'h0;
    #1 got = rdata;
  endtask : rd
  task automatic pulse(input logic [1:0] s);
    @(posedge tb);
    @(posedge clk);
    ttrg = cyc;
    if (s == 2'h0) wr(OFS_CMD, 32'h2);
    else begin
      {pfire, etrig} <= s;
      repeat (4) @(posedge clk);
      {pfire, etrig} <= 2'h0;
    end
  endtask : pulse
  task automatic run(input logic [31:0] c, input logic [15:0] dv, input logic [15:0] d,
                     input logic [27:0] n, input logic [30:0] r, input int k, input logic dbl);
    wr(OFS_CTRL, c);
    wr(OFS_SAMPLE_INTERVAL_DIVIDER, {16'h0, dv});
    wr(OFS_TRIGGER_DELAY_COUNT, {16'h0, d});
    wr(OFS_SAMPLE_TOTAL_COUNT, {4'h0, n});
    wr(OFS_TRACE_REPEAT_COUNT, {1'h0, r});
    wr(OFS_CMD, 32'h1);
    nwr = 0;
    ntro = 0;
    for (int i = 0; i < k; i++) begin
      a0 <= 16'h0064 + 16'(i) * 16'h00C8;
      repeat (200) @(posedge clk);
      if (i == 0) chk(nwr, 0);
      pulse(c[9:8]);
      // second trigger falls in the trace
      if (dbl) pulse(c[9:8]);
    end
    repeat (300) @(posedge clk);
  endtask : run
  task automatic conclude();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude
  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    {wr_s, rd_s, etrig, pfire, cyc, nwr, ntro, addr, wdata, sw, prdy, a0, a1} = '0;
    rst = 1'h1;
    repeat (5) @(posedge clk);
    chk({30'h0, rsel}, 32'h0);
    rst <= 1'h0;
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      rd(rows[i].a);
      chk(got, rows[i].e);
    end
    for (int v = 6; v <= 15; v += 9) begin
      sw <= 4'(v);
      repeat (8) @(posedge clk);
      rd(OFS_STATUS);
      chk({22'h0, got[9:0]}, 32'h1 | (v << 6));
    end
    for (int k = 0; k < 3; k++) begin
      wr(OFS_CTRL, 32'(k) << 4);
      repeat (2) @(posedge clk);
      chk({direct, rsel}, {k == 2, k == 1 ? REF_CLKIN : REF_OSC});
    end
    a1 <= 16'hABCD;
    for (int s = 0; s < 3; s++) begin
      run(32'(s) << 8, 16'h1, 16'h1, 28'h3, 31'h2, 2, 1'h1);
      chk(nwr, 6);
      chk(last, {16'hABCD, 16'h012C});
    end
    run(32'h0, 16'h3, 16'h1, 28'h2, 31'h1, 1, 1'h0);
    chk(tlast - tprev, 24);
    p0 = tfirst - ttrg;
    run(32'h1, 16'h3, 16'h2, 28'h2, 31'h1, 1, 1'h0);
    chk(tfirst - ttrg, p0 + 16);
    run(32'h4, 16'h1, 16'h1, 28'h1, 31'h2, 2, 1'h0);
    chk({last, 32'(nwr)}, {16'hABCD, 16'h00C8, 32'h1});
    run(32'h40, 16'h1, 16'h1, 28'h1, 31'h1, 1, 1'h0);
    chk({troe, tboe, 30'(ntro)}, {2'h3, 30'h1});
    run(32'h280, 16'h1, 16'h1, 28'h1, 31'h1, 1, 1'h0);
    chk({rsel, 30'(nwr)}, {REF_SHARED, 30'h1});
    wr(OFS_CTRL, 32'h1283);
    wr(OFS_CMD, 32'h1);
    repeat (20) @(posedge clk);
    chk({roe, rout}, 8'h4F);
    conclude();
  end
  initial begin
    repeat (40000) @(posedge clk);
    bad_count++;
    conclude();
  end
endmodule : dat_acq_timing_tb_top
